// [logic/rtcint_pkg.sv]
package rtcint_pkg;

    // ========
    // Register offsets
    localparam logic [7:0] ADDR_ALARM_MINUTE    = 8'h07;
    localparam logic [7:0] ADDR_ALARM_HOUR      = 8'h08;
    localparam logic [7:0] ADDR_ALARM_DAY       = 8'h09;
    localparam logic [7:0] ADDR_COUNTDOWN_VALUE = 8'h0A;
    localparam logic [7:0] ADDR_SELECT_CONFIG   = 8'h0B;
    localparam logic [7:0] ADDR_EVENT_FLAGS     = 8'h0C;
    localparam logic [7:0] ADDR_CONTROL         = 8'h0D;

    // ========
    // Field positions
    localparam int SEL_CLOCK_SELECT_LO = 2;
    localparam int SEL_ALARM_KIND      = 1;
    localparam int SEL_UPDATE_DIGIT    = 0;
    localparam int FLG_TIMER           = 2;
    localparam int FLG_ALARM           = 1;
    localparam int FLG_UPDATE          = 0;
    localparam int CTL_DIV_RESET       = 7;
    localparam int CTL_SQUARE_IRQ_EN   = 4;
    localparam int CTL_COUNTDOWN_RUN   = 3;
    localparam int CTL_COUNTDOWN_IRQ   = 2;
    localparam int CTL_ALARM_IRQ       = 1;
    localparam int CTL_UPDATE_IRQ      = 0;

    // ========
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ========
    // Source clock selections
    typedef enum logic [1:0] {
        RTCINT_SRC_4096HZ = 2'h0,
        RTCINT_SRC_64HZ   = 2'h1,
        RTCINT_SRC_1HZ    = 2'h2,
        RTCINT_SRC_MINUTE = 2'h3
    } rtcint_src_t;

    // ========
    // Timing
    localparam int OSC_HZ            = 32768;
    localparam int SECONDS_PER_MIN   = 60;
    localparam int PULSE_SHORT_NS    = 122000;
    localparam int PULSE_LONG_NS     = 7810000;
    localparam longint NS_PER_S      = 64'h3B9ACA00;
    // Nearest whole oscillator tick
    localparam int PULSE_SHORT_TICKS =
        int'((64'(PULSE_SHORT_NS) * OSC_HZ + NS_PER_S / 2) / NS_PER_S);
    localparam int PULSE_LONG_TICKS  =
        int'((64'(PULSE_LONG_NS) * OSC_HZ + NS_PER_S / 2) / NS_PER_S);
    localparam int PULSE_CNT_W       = 9;

endpackage

// [logic/rtcint_tick_if.sv]
`timescale 1ns/1ps
interface rtcint_tick_if;
    logic divReset;
    logic tick32k;
    logic tick4096;
    logic tick64;
    logic tick1Hz;
    logic tickMinute;
    logic squareLow;

    modport source (
        input  divReset,
        output tick32k,
        output tick4096,
        output tick64,
        output tick1Hz,
        output tickMinute,
        output squareLow
    );
    modport sink (
        output divReset,
        input  tick32k,
        input  tick4096,
        input  tick64,
        input  tick1Hz,
        input  tickMinute,
        input  squareLow
    );
endinterface

// [logic/rtcint_divider.sv]
`timescale 1ns/1ps
module rtcint_divider
#(
    parameter int CLK_HZ = 100000000
) (
    input  wire logic   ref_clk,
    input  wire logic   rst,
    rtcint_tick_if.source ticks
);
    import rtcint_pkg::*;

    // ========
    // Parameter check
    if (CLK_HZ < 2 * OSC_HZ) begin : gBadClk
        $error("CLK_HZ too low for the oscillator tick");
    end

    // ========
    // Fractional phase accumulator, average rate is exact
    logic [31:0] phase_reg, phase_next;
    logic [14:0] div_reg, div_next;
    logic [5:0]  sec_reg, sec_next;
    logic        t32_reg, t32_next;
    logic        t4k_reg, t4k_next;
    logic        t64_reg, t64_next;
    logic        t1_reg, t1_next;
    logic        tMin_reg, tMin_next;
    logic        sq_reg, sq_next;

    always_comb begin
        logic [32:0] sum;
        sum = 33'(phase_reg) + 33'(OSC_HZ);
        t32_next  = 1'b0;
        phase_next = sum[31:0];
        if (sum >= 33'(CLK_HZ)) begin
            phase_next = 32'(sum - 33'(CLK_HZ));
            t32_next   = 1'b1;
        end
        div_next  = div_reg;
        sec_next  = sec_reg;
        t4k_next  = 1'b0;
        t64_next  = 1'b0;
        t1_next   = 1'b0;
        tMin_next = 1'b0;
        if (t32_next) begin
            div_next = div_reg + 15'h1;
            // Ticks mark the falling edge of each stage
            t4k_next = (div_reg[2:0] == 3'h7);
            t64_next = (div_reg[8:0] == 9'h1FF);
            t1_next  = (div_reg == 15'h7FFF);
            if (t1_next) begin
                if (sec_reg == 6'(SECONDS_PER_MIN - 1)) begin
                    sec_next  = 6'h0;
                    tMin_next = 1'b1;
                end else begin
                    sec_next = sec_reg + 6'h1;
                end
            end
        end
        // Slow stages held while divider reset is set
        if (ticks.divReset) begin
            div_next  = {6'h00, div_next[8:0]};
            sec_next  = 6'h0;
            t1_next   = 1'b0;
            tMin_next = 1'b0;
        end
        sq_next = div_next[14];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_reg <= 32'h0;
            div_reg   <= 15'h0;
            sec_reg   <= 6'h0;
            t32_reg   <= 1'b0;
            t4k_reg   <= 1'b0;
            t64_reg   <= 1'b0;
            t1_reg    <= 1'b0;
            tMin_reg  <= 1'b0;
            sq_reg    <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            div_reg   <= div_next;
            sec_reg   <= sec_next;
            t32_reg   <= t32_next;
            t4k_reg   <= t4k_next;
            t64_reg   <= t64_next;
            t1_reg    <= t1_next;
            tMin_reg  <= tMin_next;
            sq_reg    <= sq_next;
        end
    end

    assign ticks.tick32k    = t32_reg;
    assign ticks.tick4096   = t4k_reg;
    assign ticks.tick64     = t64_reg;
    assign ticks.tick1Hz    = t1_reg;
    assign ticks.tickMinute = tMin_reg;
    assign ticks.squareLow  = sq_reg;
endmodule

// [logic/rtcint_unit.sv]
`timescale 1ns/1ps
module rtcint_unit
#(
    parameter int CLK_HZ = 100000000
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData,
    input  wire logic       busStopSeen,
    input  wire logic       secondsChanged,
    input  wire logic       minutesChanged,
    input  wire logic       minuteCarry,
    input  wire logic [7:0] curMinute,
    input  wire logic [7:0] curHour,
    input  wire logic [7:0] curWeekday,
    input  wire logic [7:0] curDay,
    output logic            intN
);
    import rtcint_pkg::*;

    // ========
    // Helpers
    // Set wins over a clear in the same cycle
    function automatic logic flagNext(input logic cur, input logic set,
                                      input logic clr);
        return set | (cur & ~clr);
    endfunction

    function automatic logic isWrite(input logic en, input logic [7:0] a,
                                     input logic [7:0] off);
        return en && (a == off);
    endfunction

    // ========
    // Divider chain
    rtcint_tick_if ticks ();

    rtcint_divider #(
        .CLK_HZ (CLK_HZ)
    ) uDivider (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ticks   (ticks)
    );

    // ========
    // Register file
    logic [7:0] almMin_reg, almMin_next;
    logic [7:0] almHour_reg, almHour_next;
    logic [7:0] almDay_reg, almDay_next;
    logic [7:0] cdValue_reg, cdValue_next;
    logic [7:0] select_reg, select_next;
    logic [7:0] control_reg, control_next;
    logic [7:0] rdData_reg, rdData_next;
    logic       wrFlags;
    logic       wrControl;

    assign wrFlags   = isWrite(regWrEn, regAddr, ADDR_EVENT_FLAGS);
    assign wrControl = isWrite(regWrEn, regAddr, ADDR_CONTROL);

    always_comb begin
        almMin_next  = almMin_reg;
        almHour_next = almHour_reg;
        almDay_next  = almDay_reg;
        cdValue_next = cdValue_reg;
        select_next  = select_reg;
        control_next = control_reg;
        // Alarm and count bytes are always plain storage
        if (isWrite(regWrEn, regAddr, ADDR_ALARM_MINUTE)) begin
            almMin_next = regWrData;
        end
        if (isWrite(regWrEn, regAddr, ADDR_ALARM_HOUR)) begin
            almHour_next = regWrData;
        end
        if (isWrite(regWrEn, regAddr, ADDR_ALARM_DAY)) begin
            almDay_next = regWrData;
        end
        if (isWrite(regWrEn, regAddr, ADDR_COUNTDOWN_VALUE)) begin
            cdValue_next = regWrData;
        end
        if (isWrite(regWrEn, regAddr, ADDR_SELECT_CONFIG)) begin
            select_next = regWrData;
        end
        if (wrControl) begin
            control_next = regWrData;
        end else if (busStopSeen) begin
            // Divider reset self-clears at the end of a bus transfer
            control_next[CTL_DIV_RESET] = 1'b0;
        end
    end

    // ========
    // Countdown timer
    typedef enum logic [1:0] {
        RTCINT_CD_IDLE,
        RTCINT_CD_COUNT
    } rtcint_cd_state_t;

    rtcint_cd_state_t cdState_reg, cdState_next;
    logic [7:0] cdCount_reg, cdCount_next;
    logic       srcTick;
    logic       cdFire;
    rtcint_src_t srcSel;

    assign srcSel = rtcint_src_t'(select_reg[SEL_CLOCK_SELECT_LO +: 2]);

    always_comb begin
        case (srcSel)
            RTCINT_SRC_4096HZ: srcTick = ticks.tick4096;
            RTCINT_SRC_64HZ:   srcTick = ticks.tick64;
            RTCINT_SRC_1HZ:    srcTick = ticks.tick1Hz;
            default:           srcTick = ticks.tickMinute;
        endcase
    end

    always_comb begin
        cdState_next = cdState_reg;
        cdCount_next = cdCount_reg;
        cdFire       = 1'b0;
        case (cdState_reg)
            RTCINT_CD_IDLE: begin
                // First counted edge is the one after the write
                if (wrControl && regWrData[CTL_COUNTDOWN_RUN]) begin
                    cdState_next = RTCINT_CD_COUNT;
                    cdCount_next = cdValue_reg;
                end
            end
            RTCINT_CD_COUNT: begin
                if (!control_reg[CTL_COUNTDOWN_RUN]) begin
                    cdState_next = RTCINT_CD_IDLE;
                end else if (wrControl) begin
                    cdCount_next = cdValue_reg;
                    if (!regWrData[CTL_COUNTDOWN_RUN]) begin
                        cdState_next = RTCINT_CD_IDLE;
                    end
                end else if (srcTick && cdCount_reg != 8'h00) begin
                    if (cdCount_reg == 8'h01) begin
                        cdFire       = 1'b1;
                        cdCount_next = cdValue_reg;
                    end else begin
                        cdCount_next = cdCount_reg - 8'h01;
                    end
                end else if (srcTick) begin
                    // Zero count never fires; pick up a new value
                    cdCount_next = cdValue_reg;
                end
            end
            default: begin
                cdState_next = RTCINT_CD_IDLE;
            end
        endcase
    end

    // ========
    // Alarm and update events
    logic alarmMatch;
    logic dayMatch;
    logic updEvent;

    always_comb begin
        if (select_reg[SEL_ALARM_KIND]) begin
            dayMatch = (almDay_reg == curDay);
        end else begin
            dayMatch = ((almDay_reg & curWeekday) != 8'h00);
        end
        alarmMatch = minuteCarry && (almMin_reg == curMinute)
                     && (almHour_reg == curHour) && dayMatch;
        // Digit changes are ignored while the divider is held
        updEvent = !control_reg[CTL_DIV_RESET] &&
                   (select_reg[SEL_UPDATE_DIGIT] ? minutesChanged
                                                 : secondsChanged);
    end

    // ========
    // Flags and pulses
    logic       tFlag_reg, tFlag_next;
    logic       aFlag_reg, aFlag_next;
    logic       uFlag_reg, uFlag_next;
    logic [PULSE_CNT_W-1:0] tPulse_reg, tPulse_next;
    logic [PULSE_CNT_W-1:0] uPulse_reg, uPulse_next;
    logic       intN_reg, intN_next;
    logic       pinLow;

    always_comb begin
        // Writing one is ignored, zero clears
        tFlag_next = flagNext(tFlag_reg, cdFire,
                              wrFlags && !regWrData[FLG_TIMER]);
        aFlag_next = flagNext(aFlag_reg, alarmMatch,
                              wrFlags && !regWrData[FLG_ALARM]);
        uFlag_next = flagNext(uFlag_reg, updEvent,
                              wrFlags && !regWrData[FLG_UPDATE]);

        tPulse_next = tPulse_reg;
        if (cdFire && control_reg[CTL_COUNTDOWN_IRQ]) begin
            tPulse_next = (srcSel == RTCINT_SRC_4096HZ)
                ? PULSE_CNT_W'(PULSE_SHORT_TICKS)
                : PULSE_CNT_W'(PULSE_LONG_TICKS);
        end else if (!tFlag_next) begin
            tPulse_next = '0;
        end else if (ticks.tick32k && tPulse_reg != '0) begin
            tPulse_next = tPulse_reg - PULSE_CNT_W'(1);
        end

        uPulse_next = uPulse_reg;
        if (updEvent && control_reg[CTL_UPDATE_IRQ]) begin
            uPulse_next = PULSE_CNT_W'(PULSE_LONG_TICKS);
        end else if (!uFlag_next) begin
            uPulse_next = '0;
        end else if (ticks.tick32k && uPulse_reg != '0) begin
            uPulse_next = uPulse_reg - PULSE_CNT_W'(1);
        end

        // Alarm holds the pin until its flag is cleared
        pinLow = (tPulse_next != '0)
                 || (aFlag_next && control_reg[CTL_ALARM_IRQ])
                 || (uPulse_next != '0)
                 || (control_reg[CTL_SQUARE_IRQ_EN] && ticks.squareLow);
        intN_next = !pinLow;
    end

    // ========
    // Read path, one cycle after the address
    always_comb begin
        case (regAddr)
            ADDR_ALARM_MINUTE:    rdData_next = almMin_reg;
            ADDR_ALARM_HOUR:      rdData_next = almHour_reg;
            ADDR_ALARM_DAY:       rdData_next = almDay_reg;
            ADDR_COUNTDOWN_VALUE: rdData_next = cdValue_reg;
            ADDR_SELECT_CONFIG:   rdData_next = select_reg;
            ADDR_EVENT_FLAGS:     rdData_next = {5'h00, tFlag_reg,
                                                 aFlag_reg, uFlag_reg};
            ADDR_CONTROL:         rdData_next = control_reg;
            default:              rdData_next = 8'h00;
        endcase
    end

    // ========
    // State registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            almMin_reg  <= RST_BYTE;
            almHour_reg <= RST_BYTE;
            almDay_reg  <= RST_BYTE;
            cdValue_reg <= RST_BYTE;
            select_reg  <= RST_BYTE;
            control_reg <= RST_BYTE;
            rdData_reg  <= RST_BYTE;
            cdState_reg <= RTCINT_CD_IDLE;
            cdCount_reg <= 8'h00;
            tFlag_reg   <= 1'b0;
            aFlag_reg   <= 1'b0;
            uFlag_reg   <= 1'b0;
            tPulse_reg  <= '0;
            uPulse_reg  <= '0;
            intN_reg    <= 1'b1;
        end else begin
            almMin_reg  <= almMin_next;
            almHour_reg <= almHour_next;
            almDay_reg  <= almDay_next;
            cdValue_reg <= cdValue_next;
            select_reg  <= select_next;
            control_reg <= control_next;
            rdData_reg  <= rdData_next;
            cdState_reg <= cdState_next;
            cdCount_reg <= cdCount_next;
            tFlag_reg   <= tFlag_next;
            aFlag_reg   <= aFlag_next;
            uFlag_reg   <= uFlag_next;
            tPulse_reg  <= tPulse_next;
            uPulse_reg  <= uPulse_next;
            intN_reg    <= intN_next;
        end
    end

    assign ticks.divReset = control_reg[CTL_DIV_RESET];
    assign regRdData      = rdData_reg;
    assign intN           = intN_reg;
endmodule

// [bench/rtcint_properties.sv]
`timescale 1ns/1ps
// ========
// Port-level checks of the interrupt unit
module rtcint_properties
    import rtcint_pkg::*;
#(
    parameter int CLK_HZ = 100000000
) (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       regWrEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic       busStopSeen,
    input wire logic       secondsChanged,
    input wire logic       minutesChanged,
    input wire logic       intN
);
    localparam int SHORT_CYC = PULSE_SHORT_TICKS * CLK_HZ / OSC_HZ;
    localparam int SHORT_LO  = SHORT_CYC - 2;
    localparam int SHORT_HI  = SHORT_CYC + 1;
    logic [7:0] ctl_reg, ctl_next, sel_reg, sel_next;
    logic [3:0] quiet_reg, quiet_next;
    int         lowCnt_reg, lowCnt_next;
    wire logic [3:0] irqEn = {ctl_reg[4], ctl_reg[2:0]};

    // ========
    // Shadow of control and select, pin counters
    always_comb begin
        ctl_next = ctl_reg;
        sel_next = sel_reg;
        if (regWrEn && regAddr == ADDR_CONTROL) begin
            ctl_next = regWrData;
        end
        if (regWrEn && regAddr == ADDR_SELECT_CONFIG) begin
            sel_next = regWrData;
        end
        // Control write beats the stop pulse, as in the unit
        if (regWrEn && regAddr == ADDR_CONTROL) begin
        end
        else if (busStopSeen) begin
            ctl_next[CTL_DIV_RESET] = 1'b0;
        end
        lowCnt_next = intN ? 0 : lowCnt_reg + 1;
        quiet_next = (irqEn != 4'h0) ? 4'h0 : quiet_reg;
        if (irqEn == 4'h0 && quiet_reg != 4'h8) begin
            quiet_next = quiet_reg + 4'h1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctl_reg <= 8'h00;
            sel_reg <= 8'h00;
            quiet_reg <= 4'h0;
            lowCnt_reg <= 0;
        end else begin
            ctl_reg <= ctl_next;
            sel_reg <= sel_next;
            quiet_reg <= quiet_next;
            lowCnt_reg <= lowCnt_next;
        end
    end

    // ========
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_wrMin;
        regWrEn && regAddr == ADDR_ALARM_MINUTE
            ##1 !regWrEn && regAddr == ADDR_ALARM_MINUTE;
    endsequence
    sequence s_updEv;
        ctl_reg[CTL_UPDATE_IRQ] && !ctl_reg[CTL_DIV_RESET]
            && (sel_reg[SEL_UPDATE_DIGIT] ? minutesChanged : secondsChanged);
    endsequence
    property p_reset;
        disable iff (1'b0) rst |=> intN && regRdData == 8'h00;
    endproperty
    property p_flagsHi;
        regAddr == ADDR_EVENT_FLAGS |=> regRdData[7:3] == 5'h00;
    endproperty
    property p_storage;
        s_wrMin |=> regRdData == $past(regWrData, 2);
    endproperty
    property p_quiet;
        quiet_reg == 4'h8 |-> intN;
    endproperty
    property p_clear;
        regWrEn && regAddr == ADDR_EVENT_FLAGS && regWrData[2:0] == 3'h0
            && !ctl_reg[4] && !ctl_reg[1] && !secondsChanged
            && !minutesChanged |-> ##[1:2] intN;
    endproperty
    property p_upd;
        s_updEv |-> ##[1:2] !intN;
    endproperty
    property p_updHold;
        s_updEv ##2 !intN |-> !intN [*8];
    endproperty
    property p_short;
        $rose(intN) && irqEn == 4'b0100 && sel_reg[3:2] == 2'h0
            |-> lowCnt_reg inside {[SHORT_LO:SHORT_HI]};
    endproperty
    a_reset: assert property (p_reset)
        else $error("pin or read data active during reset");
    a_flagsHi: assert property (p_flagsHi)
        else $error("unused flag bits read nonzero");
    a_storage: assert property (p_storage)
        else $error("alarm minute not stored");
    a_quiet: assert property (p_quiet)
        else $error("pin low with all sources disabled");
    a_clear: assert property (p_clear)
        else $error("pin not released after flag clear");
    a_upd: assert property (p_upd)
        else $error("no pin pulse after update event");
    a_updHold: assert property (p_updHold)
        else $error("update pulse ended early");
    a_short: assert property (p_short)
        else $error("short timer pulse width wrong");
endmodule

bind rtcint_unit rtcint_properties #(.CLK_HZ(CLK_HZ)) rtcint_properties_i (
    .ref_clk(ref_clk), .rst(rst), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData),
    .busStopSeen(busStopSeen), .secondsChanged(secondsChanged),
    .minutesChanged(minutesChanged), .intN(intN)
);

// [bench/rtcint_host_model.sv]
`timescale 1ns/1ps
// ========
// Host side sampling the active-low request line
module rtcint_host_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic intN,
    output int        fallCount,
    output int        lowLen,
    output int        fallGap
);
    int   lowRun;
    int   sinceFall;
    logic intPrev;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fallCount <= 0;
            lowLen <= 0;
            fallGap <= 0;
            lowRun <= 0;
            sinceFall <= 0;
            intPrev <= 1'b1;
        end else begin
            intPrev <= intN;
            lowRun <= intN ? 0 : lowRun + 1;
            sinceFall <= sinceFall + 1;
            if (intPrev && !intN) begin
                fallCount <= fallCount + 1;
                fallGap <= sinceFall;
                sinceFall <= 1;
            end
            if (!intPrev && intN) begin
                lowLen <= lowRun;
            end
        end
    end
endmodule

// [bench/rtcint_unit_bench.sv]
`timescale 1ns/1ps
module rtcint_unit_bench;
    import rtcint_pkg::*;
    // Slowest legal rate keeps pulses and periods short in simulation
    localparam int SIM_HZ = 65536;
    localparam int TCK    = SIM_HZ / OSC_HZ;
    localparam int SHORTC = PULSE_SHORT_TICKS * TCK;
    localparam int LONGC  = PULSE_LONG_TICKS * TCK;
    localparam int S4096  = SIM_HZ / 4096;
    localparam int S64    = SIM_HZ / 64;
    localparam int LIMIT  = 12000;
    logic       ref_clk, rst, regWrEn, busStopSeen, intN;
    logic       secondsChanged, minutesChanged, minuteCarry;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [7:0] curMinute, curHour, curWeekday, curDay;
    int         fails, checkCount, cycles, fallCount, lowLen, fallGap;

    rtcint_unit #(.CLK_HZ(SIM_HZ)) rtcint_unit_i (.ref_clk(ref_clk),
        .rst(rst), .regWrEn(regWrEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData),
        .busStopSeen(busStopSeen), .secondsChanged(secondsChanged),
        .minutesChanged(minutesChanged), .minuteCarry(minuteCarry),
        .curMinute(curMinute), .curHour(curHour),
        .curWeekday(curWeekday), .curDay(curDay), .intN(intN));
    rtcint_host_model rtcint_host_model_i (.ref_clk(ref_clk), .rst(rst),
        .intN(intN), .fallCount(fallCount), .lowLen(lowLen),
        .fallGap(fallGap));

    // ========
    // Shared tasks
    task stop_test();
        $display("Checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task check(string w, logic [7:0] e, logic [7:0] g);
        checkCount++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %0h seen %0h", w, e, g);
        end
    endtask
    task inRange(string w, int lo, int hi, int g);
        checkCount++;
        if (g < lo || g > hi) begin
            fails++;
            $display("Error %s expected %0d..%0d seen %0d", w, lo, hi, g);
        end
    endtask
    task wr(logic [7:0] a, logic [7:0] d);
        @(negedge ref_clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge ref_clk);
        regWrEn = 1'b0;
    endtask
    task rd(logic [7:0] a, logic [7:0] e, string w);
        @(negedge ref_clk);
        regAddr = a;
        repeat (2) @(negedge ref_clk);
        check(w, e, regRdData);
    endtask
    task automatic pulse(ref logic s);
        @(negedge ref_clk);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
    endtask
    task waitFalls(int maxCyc);
        int start;
        start = fallCount;
        repeat (maxCyc) begin
            @(negedge ref_clk);
            if (fallCount > start) return;
        end
        check("pin fall", 8'h01, 8'h00);
    endtask
    task settle(int n, logic [7:0] e, string w);
        repeat (n) @(negedge ref_clk);
        check(w, e, {7'h00, intN});
    endtask

    // ========
    // Scenarios
    task t_reset();
        check("pin idle", 8'h01, {7'h00, intN});
        for (int a = 7; a <= 13; a++) begin
            rd(8'(a), 8'h00, "reset value");
        end
        rd(8'h20, 8'h00, "unmapped");
    endtask
    task t_storage();
        wr(ADDR_COUNTDOWN_VALUE, 8'hA5);
        rd(ADDR_COUNTDOWN_VALUE, 8'hA5, "count store");
        wr(ADDR_ALARM_MINUTE, 8'h5A);
        rd(ADDR_ALARM_MINUTE, 8'h5A, "alarm store");
        wr(ADDR_EVENT_FLAGS, 8'hFF);
        rd(ADDR_EVENT_FLAGS, 8'h00, "flag write one");
    endtask
    task t_timerShort();
        wr(ADDR_EVENT_FLAGS, 8'h00);
        wr(ADDR_COUNTDOWN_VALUE, 8'h02);
        wr(ADDR_SELECT_CONFIG, 8'h00);
        wr(ADDR_CONTROL, 8'h0C);
        waitFalls(6 * S4096);
        rd(ADDR_EVENT_FLAGS, 8'h04, "timer flag");
        waitFalls(6 * S4096);
        settle(3 * SHORTC, 8'h01, "short end");
        inRange("short pulse", SHORTC - 2, SHORTC + 1, lowLen);
        inRange("period", S4096, 3 * S4096, fallGap);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_EVENT_FLAGS, 8'h00);
        rd(ADDR_COUNTDOWN_VALUE, 8'h02, "count kept");
    endtask
    task t_timerLong();
        wr(ADDR_COUNTDOWN_VALUE, 8'h01);
        wr(ADDR_SELECT_CONFIG, 8'h04);
        wr(ADDR_CONTROL, 8'h0C);
        waitFalls(3 * S64);
        settle(LONGC + 4, 8'h01, "long end");
        inRange("long pulse", LONGC - 2, LONGC + 1, lowLen);
        waitFalls(2 * S64);
        settle(10, 8'h00, "long active");
        wr(ADDR_EVENT_FLAGS, 8'h00);
        settle(2, 8'h01, "timer release");
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_EVENT_FLAGS, 8'h00);
    endtask
    task t_timerMasked();
        int start;
        start = fallCount;
        wr(ADDR_SELECT_CONFIG, 8'h00);
        wr(ADDR_CONTROL, 8'h08);
        repeat (4 * S4096) @(negedge ref_clk);
        rd(ADDR_EVENT_FLAGS, 8'h04, "masked flag");
        inRange("masked falls", start, start, fallCount);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_EVENT_FLAGS, 8'h00);
    endtask
    task t_update();
        wr(ADDR_CONTROL, 8'h01);
        pulse(minutesChanged);
        rd(ADDR_EVENT_FLAGS, 8'h00, "minute ignored");
        pulse(secondsChanged);
        rd(ADDR_EVENT_FLAGS, 8'h01, "second flag");
        settle(20, 8'h00, "update pin");
        wr(ADDR_EVENT_FLAGS, 8'h00);
        settle(2, 8'h01, "update release");
        wr(ADDR_SELECT_CONFIG, 8'h01);
        pulse(secondsChanged);
        rd(ADDR_EVENT_FLAGS, 8'h00, "second ignored");
        pulse(minutesChanged);
        rd(ADDR_EVENT_FLAGS, 8'h01, "minute flag");
        settle(20, 8'h00, "minute pin");
        wr(ADDR_EVENT_FLAGS, 8'h00);
        wr(ADDR_CONTROL, 8'h81);
        pulse(minutesChanged);
        rd(ADDR_EVENT_FLAGS, 8'h00, "divider held");
        pulse(busStopSeen);
        rd(ADDR_CONTROL, 8'h01, "stop clears");
        wr(ADDR_CONTROL, 8'h00);
    endtask
    task t_alarm();
        wr(ADDR_ALARM_MINUTE, 8'h30);
        wr(ADDR_ALARM_HOUR, 8'h07);
        wr(ADDR_ALARM_DAY, 8'h3E);
        wr(ADDR_SELECT_CONFIG, 8'h00);
        wr(ADDR_EVENT_FLAGS, 8'h00);
        wr(ADDR_CONTROL, 8'h02);
        curMinute = 8'h30;
        curHour = 8'h07;
        curDay = 8'h3E;
        pulse(minuteCarry);
        rd(ADDR_EVENT_FLAGS, 8'h00, "weekday miss");
        curWeekday = 8'h04;
        pulse(minuteCarry);
        rd(ADDR_EVENT_FLAGS, 8'h02, "alarm flag");
        check("alarm pin", 8'h00, {7'h00, intN});
        wr(ADDR_EVENT_FLAGS, 8'h00);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_SELECT_CONFIG, 8'h02);
        curWeekday = 8'h00;
        pulse(minuteCarry);
        rd(ADDR_EVENT_FLAGS, 8'h02, "day alarm");
        check("alarm masked", 8'h01, {7'h00, intN});
        wr(ADDR_EVENT_FLAGS, 8'h00);
    endtask

    // ========
    // Clock, watchdog and main sequence
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        {regWrEn, busStopSeen, secondsChanged, minutesChanged} = 4'h0;
        {minuteCarry, regAddr, regWrData} = 17'h00000;
        {curMinute, curHour, curWeekday, curDay} = 32'h00000000;
        rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        t_reset();
        t_storage();
        t_timerShort();
        t_timerLong();
        t_timerMasked();
        t_update();
        t_alarm();
        stop_test();
    end
endmodule
